// ==== src/i2c_hs_pkg.sv ====
//
// Behaviour
// - arbitration lost while receiving raises master flag, never slave flag
// - smart mode: slave flag only after byte received and ack sent
// - high-speed entry sends 00001nnn master code at full speed, NACKed
// - arbitration checked only before high speed is entered
// - master flag raised after master code and its NACK
// - address with high-speed select, bus_speed high and clock_stretch_mode set gives repeated start at high speed
// - high speed stays until a stop is generated
// - ten-bit write address sends two bytes, a read only the first, then the transaction continues
// - NACK on first ten-bit byte raises master flag and nack status
// - ACK on first ten-bit byte of a write sends second byte without flag
package i2c_hs_pkg;
    localparam int CLK_NS = 25;
    localparam int TQ_FS_NS = 625;  // quarter bit at full speed
    localparam int TQ_HS_NS = 74;   // quarter bit at high speed
    // least times, rounded up to whole cycles
    localparam int TQ_FS_CYC = (TQ_FS_NS + CLK_NS - 1) / CLK_NS;
    localparam int TQ_HS_CYC = (TQ_HS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CW = 8;
    localparam logic [CW-1:0] HALF_FS = CW'(2 * TQ_FS_CYC);
    localparam logic [CW-1:0] HALF_HS = CW'(2 * TQ_HS_CYC);
    localparam logic [CW-1:0] ONE_CNT = 8'h01;
    localparam int ADDR_W = 11;     // [10:1] address, [0] direction
    localparam int A_HI = ADDR_W - 1;
    localparam logic [1:0] SPEED_HS = 2'h2;
    localparam logic [4:0] TEN_PREFIX = 5'h1E;
    localparam logic [4:0] MCODE_PREFIX = 5'h01;
    localparam logic [8:0] OWN_BYTE = 9'h1FE;
    localparam logic [8:0] OWN_ACK = 9'h001;
    localparam logic [8:0] OWN_TOP = 9'h100;
    localparam logic [8:0] OWN_NONE = 9'h000;
    localparam logic [8:0] SH_REL = 9'h1FF;
    localparam logic [3:0] NB_FULL = 4'h9;
    localparam logic [3:0] NB_DATA = 4'h8;
    localparam logic [3:0] NB_ONE = 4'h1;
    localparam int FR_W = 22;
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_STOP
    } state_type;
    typedef enum logic [1:0] {PH_A, PH_B, PH_C} ph_type;
    typedef enum logic [2:0] {
        K_MCODE, K_ADDR1, K_ADDR2, K_ADDR, K_RXB, K_ACK, K_RXS
    } kind_type;
endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/10ps

module pin_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r, s2_r, s3_r, out_r;

    // idle bus lines are high, so everything resets to one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            out_r <= '1;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // change only once stages two and three agree
            out_r <= (s2_r & s3_r) | (out_r & (s2_r | s3_r));
        end
    end

    assign dout = out_r;
endmodule

// ==== src/byte_fifo.sv ====
`timescale 1ns/10ps

module byte_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // pointer wrap trick needs a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("byte_fifo depth must be a power of two");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r, rp_r;
    wire wr = in_valid && in_ready;
    wire rd = out_valid && out_ready;

    // extra pointer bit tells full from empty
    assign in_ready = !(wp_r[AW] != rp_r[AW] &&
                        wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign out_valid = wp_r != rp_r;
    assign out_data = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (AW+1)'(wr);
            rp_r <= rp_r + (AW+1)'(rd);
        end
    end

    // storage needs no reset, pointers guard it
    always_ff @(posedge clk) begin
        if (wr) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==== src/i2c_addr_master.sv ====
`timescale 1ns/10ps

module i2c_addr_master
    import i2c_hs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_wr,
    input wire logic [ADDR_W-1:0] addr_val,
    input wire logic high_speed_select,
    input wire logic ten_bit_addr_enable,
    input wire logic [1:0] bus_speed,
    input wire logic clock_stretch_mode,
    input wire logic ack_action,
    input wire logic cmd_continue,
    input wire logic cmd_stop,
    input wire logic mb_clr,
    input wire logic sb_clr,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic master_on_bus_flag,
    output logic slave_on_bus_flag,
    output logic received_nack,
    output logic arb_lost,
    output logic hs_active,
    output logic bus_busy
);
    if (FIFO_DEPTH < 2) begin : g_bad_fifo
        $error("receive fifo too shallow");
    end

    state_type st_r;
    ph_type ph_r;
    kind_type kind_r;
    logic [CW-1:0] cnt_r;
    logic [8:0] sh_r, own_r;
    logic [3:0] nb_r;
    logic [7:0] rx_sh_r;
    logic [ADDR_W-1:0] addr_r;
    logic scl_low_r, sda_low_r, last_in_r;
    logic mb_r, sb_r, nack_r, arb_r, hs_r;
    logic want_rx_r, pend_ack_r, stop_pend_r, smart_r, nack_sent_r;
    logic [1:0] pin_s;
    logic fifo_room;

    pin_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({scl_in, sda_in}),
        .dout(pin_s)
    );

    // timing: counts pause while a slave holds SCL low
    wire scl_hi = pin_s[1];
    wire sda_s = pin_s[0];
    wire [CW-1:0] half = hs_r ? HALF_HS : HALF_FS;
    wire [CW-1:0] qtr = half >> 1;
    wire timed = st_r == ST_START || st_r == ST_BIT || st_r == ST_STOP;
    wire stall = !scl_low_r && !scl_hi;
    wire step = timed && !stall && cnt_r == half - ONE_CNT;
    wire smp = st_r == ST_BIT && ph_r == PH_B && cnt_r == qtr && scl_hi;
    wire bit_low = own_r[8] && !sh_r[8];

    // frame outcome decoding
    wire addr_kind = kind_r == K_ADDR1 || kind_r == K_ADDR2 ||
                     kind_r == K_ADDR;
    wire fin = st_r == ST_BIT && ph_r == PH_B && step && nb_r == NB_ONE;
    wire dir_rd = addr_r[0];
    wire ten_next = kind_r == K_ADDR1 && !last_in_r && !dir_rd;
    wire rx_next = (addr_kind && !last_in_r && dir_rd) ||
                   (kind_r == K_ACK && !stop_pend_r);
    wire stop_next = kind_r == K_ACK && stop_pend_r;
    wire rx_byte = kind_r == K_RXB || kind_r == K_RXS;
    wire rx_shift = !(kind_r == K_RXS && nb_r == NB_ONE);
    wire push = fin && rx_byte;
    wire pop = rx_valid && rx_ready;

    // a released bit read back low means another master won
    wire arb_hit = smp && own_r[8] && sh_r[8] && !sda_s && !hs_r;

    // requests from software
    wire wr_ok = addr_wr && (st_r == ST_IDLE || st_r == ST_HOLD);
    wire hs_go = high_speed_select && bus_speed == SPEED_HS &&
                 clock_stretch_mode;
    wire mcode_pat = !hs_go && !hs_r && !ten_bit_addr_enable &&
                     addr_val[7:3] == MCODE_PREFIX;
    wire kind_type kind_wr = mcode_pat ? K_MCODE :
                        (ten_bit_addr_enable ? K_ADDR1 : K_ADDR);
    wire kind_type rx_kind = smart_r ? K_RXS : K_RXB;
    wire rx_go = want_rx_r && fifo_room;
    wire auto_go = smart_r && kind_r == K_RXS && !nack_sent_r && pop;

    // flag set terms
    wire mb_set = arb_hit || (fin && (kind_r == K_MCODE ||
                  (addr_kind && (last_in_r ||
                  (!dir_rd && kind_r != K_ADDR1)))));
    wire sb_set = fin && rx_byte;
    wire nack_set = fin && addr_kind && last_in_r;

    // byte, ownership mask and bit count for a frame
    function automatic logic [FR_W-1:0] frame_of(input kind_type k);
        logic [7:0] b;
        b = addr_r[7:0];
        if (k == K_ADDR1) begin
            b = {TEN_PREFIX, addr_r[A_HI:A_HI-1], addr_r[0]};
        end else if (k == K_ADDR2) begin
            b = addr_r[A_HI-2:1];
        end
        case (k)
            K_RXB: frame_of = {SH_REL, OWN_NONE, NB_DATA};
            K_RXS: frame_of = {8'hFF, ack_action, OWN_ACK, NB_FULL};
            K_ACK: frame_of = {ack_action, 8'hFF, OWN_TOP, NB_ONE};
            default: frame_of = {b, 1'b1, OWN_BYTE, NB_FULL};
        endcase
    endfunction

    // phase counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!timed || step) begin
            cnt_r <= '0;
        end else if (!stall) begin
            cnt_r <= cnt_r + ONE_CNT;
        end
    end

    // sequencer: start, frames, hold with clock stretched, stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            ph_r <= PH_A;
            kind_r <= K_ADDR;
            sh_r <= SH_REL;
            own_r <= OWN_NONE;
            nb_r <= NB_ONE;
            rx_sh_r <= '0;
            addr_r <= '0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            last_in_r <= 1'b1;
            hs_r <= 1'b0;
            want_rx_r <= 1'b0;
            pend_ack_r <= 1'b0;
            stop_pend_r <= 1'b0;
            smart_r <= 1'b0;
            nack_sent_r <= 1'b0;
        end else if (arb_hit) begin
            st_r <= ST_IDLE;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            hs_r <= 1'b0;
            want_rx_r <= 1'b0;
            pend_ack_r <= 1'b0;
        end else if (wr_ok) begin
            addr_r <= addr_val;
            kind_r <= kind_wr;
            smart_r <= clock_stretch_mode;
            hs_r <= hs_r | hs_go;
            st_r <= ST_START;
            ph_r <= PH_A;
            sda_low_r <= 1'b0;
            want_rx_r <= 1'b0;
            pend_ack_r <= 1'b0;
        end else begin
            case (st_r)
                ST_START: begin
                    if (step && ph_r == PH_A) begin
                        scl_low_r <= 1'b0;
                        ph_r <= PH_B;
                    end else if (step && ph_r == PH_B) begin
                        sda_low_r <= 1'b1;
                        ph_r <= PH_C;
                    end else if (step) begin
                        scl_low_r <= 1'b1;
                        {sh_r, own_r, nb_r} <= frame_of(kind_r);
                        st_r <= ST_BIT;
                        ph_r <= PH_A;
                    end
                end
                ST_BIT: begin
                    if (ph_r == PH_A && cnt_r == qtr) begin
                        sda_low_r <= bit_low;
                    end
                    if (smp) begin
                        last_in_r <= sda_s;
                        if (rx_shift) begin
                            rx_sh_r <= {rx_sh_r[6:0], sda_s};
                        end
                    end
                    if (step && ph_r == PH_A) begin
                        scl_low_r <= 1'b0;
                        ph_r <= PH_B;
                    end else if (step) begin
                        scl_low_r <= 1'b1;
                        sh_r <= {sh_r[7:0], 1'b1};
                        own_r <= {own_r[7:0], 1'b0};
                        nb_r <= nb_r - NB_ONE;
                        ph_r <= PH_A;
                        if (nb_r == NB_ONE) begin
                            st_r <= ST_HOLD;
                            want_rx_r <= rx_next;
                            pend_ack_r <= kind_r == K_RXB;
                            if (ten_next) begin
                                st_r <= ST_BIT;
                                kind_r <= K_ADDR2;
                                {sh_r, own_r, nb_r} <= frame_of(K_ADDR2);
                            end else if (stop_next) begin
                                st_r <= ST_STOP;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    if (cmd_stop && pend_ack_r) begin
                        kind_r <= K_ACK;
                        {sh_r, own_r, nb_r} <= frame_of(K_ACK);
                        stop_pend_r <= 1'b1;
                        pend_ack_r <= 1'b0;
                        st_r <= ST_BIT;
                    end else if (cmd_stop) begin
                        want_rx_r <= 1'b0;
                        st_r <= ST_STOP;
                    end else if (cmd_continue && pend_ack_r) begin
                        kind_r <= K_ACK;
                        {sh_r, own_r, nb_r} <= frame_of(K_ACK);
                        stop_pend_r <= 1'b0;
                        pend_ack_r <= 1'b0;
                        st_r <= ST_BIT;
                    end else if (rx_go) begin
                        kind_r <= rx_kind;
                        {sh_r, own_r, nb_r} <= frame_of(rx_kind);
                        nack_sent_r <= ack_action;
                        want_rx_r <= 1'b0;
                        st_r <= ST_BIT;
                    end else if (auto_go) begin
                        want_rx_r <= 1'b1;
                    end
                end
                ST_STOP: begin
                    if (ph_r == PH_A && cnt_r == qtr) begin
                        sda_low_r <= 1'b1;
                    end
                    if (step && ph_r == PH_A) begin
                        scl_low_r <= 1'b0;
                        ph_r <= PH_B;
                    end else if (step && ph_r == PH_B) begin
                        sda_low_r <= 1'b0;
                        ph_r <= PH_C;
                    end else if (step) begin
                        st_r <= ST_IDLE;
                        ph_r <= PH_A;
                        hs_r <= 1'b0;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mb_r <= 1'b0;
            sb_r <= 1'b0;
            nack_r <= 1'b0;
            arb_r <= 1'b0;
        end else begin
            mb_r <= mb_set | (mb_r & ~(mb_clr | wr_ok));
            sb_r <= sb_set | (sb_r & ~(sb_clr | pop | wr_ok));
            nack_r <= nack_set | (nack_r & ~wr_ok);
            arb_r <= arb_hit | (arb_r & ~wr_ok);
        end
    end

    byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(rx_sh_r),
        .in_valid(push),
        .in_ready(fifo_room),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_low_r;
    assign sda_oe = sda_low_r;
    assign master_on_bus_flag = mb_r;
    assign slave_on_bus_flag = sb_r;
    assign received_nack = nack_r;
    assign arb_lost = arb_r;
    assign hs_active = hs_r;
    assign bus_busy = st_r != ST_IDLE;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_arb_flags;
        arb_hit |-> !sb_set ##1 (mb_r && arb_r && st_r == ST_IDLE);
    endproperty
    a_arb_flags: assert property (p_arb_flags)
        else $error("arbitration loss flagged wrongly");
    property p_smart_sb;
        sb_set && smart_r |-> kind_r == K_RXS && own_r[8];
    endproperty
    a_smart_sb: assert property (p_smart_sb)
        else $error("smart slave flag before ack");
    property p_mcode;
        fin && kind_r == K_MCODE |=> mb_r && !nack_r && st_r == ST_HOLD;
    endproperty
    a_mcode: assert property (p_mcode)
        else $error("master code end not flagged");
    property p_arb_fs;
        smp && hs_r && own_r[8] && sh_r[8] && !sda_s
        |=> st_r == ST_BIT && !arb_r;
    endproperty
    a_arb_fs: assert property (p_arb_fs)
        else $error("arbitration at high speed");
    property p_hs_rs;
        wr_ok && hs_go |=> st_r == ST_START && hs_r && kind_r != K_MCODE;
    endproperty
    a_hs_rs: assert property (p_hs_rs)
        else $error("no high speed repeated start");
    property p_hs_keep;
        $fell(hs_r) |-> $past(st_r) == ST_STOP || $past(arb_hit);
    endproperty
    a_hs_keep: assert property (p_hs_keep)
        else $error("high speed left without stop");
    property p_ten_first;
        st_r == ST_START && ph_r == PH_C && step && kind_r == K_ADDR1
        |=> sh_r[8:4] == TEN_PREFIX && nb_r == NB_FULL;
    endproperty
    a_ten_first: assert property (p_ten_first)
        else $error("bad first ten-bit byte");
    property p_ten_nack;
        fin && kind_r == K_ADDR1 && last_in_r |=> mb_r && nack_r;
    endproperty
    a_ten_nack: assert property (p_ten_nack)
        else $error("first byte nack not flagged");
    property p_ten_cont;
        fin && kind_r == K_ADDR1 && !last_in_r && !addr_r[0]
        |=> !mb_r && kind_r == K_ADDR2 && st_r == ST_BIT;
    endproperty
    a_ten_cont: assert property (p_ten_cont)
        else $error("second ten-bit byte not sent");
    property p_hold;
        st_r == ST_HOLD && mb_r && !mb_clr && !wr_ok |=> mb_r && scl_oe;
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag or clock hold dropped");

    c_hs_entry: cover property (fin && kind_r == K_MCODE
        ##[1:400] wr_ok && hs_go);
    c_ten: cover property (fin && kind_r == K_ADDR2);
    c_smart: cover property (sb_set && smart_r);
    c_arb: cover property (arb_hit);
endmodule

// ==== verif/i2c_slave_model.sv ====
`timescale 1ns/10ps

// behavioural bus slave: acks address bytes, answers reads, can stretch
module i2c_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    input wire logic clash,
    input wire logic slow,
    input wire logic [7:0] rd_byte,
    output logic sda_oe,
    output logic scl_oe,
    output logic [7:0] got_byte,
    output int got_cnt,
    output int acks,
    output logic mack
);
    int n = -1;
    logic act = 1'b0, first = 1'b0, rd = 1'b0, rd_nxt = 1'b0, drv = 1'b0;
    logic [7:0] sh = 8'h00;
    // clash plays a rival master holding data low through the first byte
    assign sda_oe = drv | (clash & first & (n >= 0) & (n < 8));
    initial begin
        scl_oe = 1'b0;
        got_byte = 8'h00;
        got_cnt = 0;
        acks = 0;
        mack = 1'b0;
    end
    // start and stop seen while the clock is high
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        first = 1'b1;
        n = -1;
        rd = 1'b0;
        drv = 1'b0;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    // sample address bits, or the master's ack after a read byte
    always @(posedge scl) if (act && n >= 0) begin
        if (rd && n == 8) begin
            mack = sda;
            acks++;
        end else if (!rd && n < 8) sh = {sh[6:0], sda};
    end
    // all own changes land while the clock is low
    always @(negedge scl) if (act) begin
        n++;
        if (n == 9) begin
            n = 0;
            drv = 1'b0;
            rd = rd ? !mack : rd_nxt;
            rd_nxt = 1'b0;
            if (slow) begin
                scl_oe = 1'b1;
                scl_oe <= #1500 1'b0;
            end
        end
        if (rd && n < 8) drv = !rd_byte[7-n];
        else if (rd) drv = 1'b0;
        else if (n == 8) begin
            got_byte = sh;
            got_cnt++;
            drv = ack_en && sh[7:3] != 5'h01;
            rd_nxt = first & sh[0] & drv;
            first = 1'b0;
        end
    end
endmodule

// ==== verif/test_i2c_addr_master.sv ====
`timescale 1ns/10ps

module test_i2c_addr_master;
    import i2c_hs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic addr_wr, high_speed_select, ten_bit_addr_enable, clock_stretch_mode;
    logic ack_action, cmd_continue, cmd_stop, mb_clr, sb_clr, rx_ready;
    logic [ADDR_W-1:0] addr_val;
    logic [1:0] bus_speed;
    logic scl_oe, sda_oe, rx_valid, master_on_bus_flag, slave_on_bus_flag;
    logic received_nack, arb_lost, hs_active, bus_busy;
    logic [7:0] rx_data, rd_byte, got_byte, st;
    logic ack_en, clash, slow, s_sda_oe, s_scl_oe, mack;
    logic scl_out, sda_out;
    int got_cnt, acks, num_errors = 0, n_tests = 0;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    wire scl_w, sda_w;
    // open drain with pull-ups
    assign scl_w = !s_scl_oe && (scl_oe ? scl_out : 1'b1);
    assign sda_w = !s_sda_oe && (sda_oe ? sda_out : 1'b1);
    assign st = {master_on_bus_flag, slave_on_bus_flag, received_nack,
        arb_lost, hs_active, bus_busy, scl_oe, sda_oe};
    always #12.5 clk = ~clk;
    i2c_addr_master i2c_addr_master_i (
        .clk(clk), .rst_n(rst_n), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_wr(addr_wr), .addr_val(addr_val),
        .high_speed_select(high_speed_select),
        .ten_bit_addr_enable(ten_bit_addr_enable), .bus_speed(bus_speed),
        .clock_stretch_mode(clock_stretch_mode), .ack_action(ack_action),
        .cmd_continue(cmd_continue), .cmd_stop(cmd_stop), .mb_clr(mb_clr),
        .sb_clr(sb_clr), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .master_on_bus_flag(master_on_bus_flag),
        .slave_on_bus_flag(slave_on_bus_flag),
        .received_nack(received_nack), .arb_lost(arb_lost),
        .hs_active(hs_active), .bus_busy(bus_busy)
    );
    i2c_slave_model i2c_slave_model_i (
        .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .clash(clash),
        .slow(slow), .rd_byte(rd_byte), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe),
        .got_byte(got_byte), .got_cnt(got_cnt), .acks(acks), .mack(mack)
    );
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait: 0 master flag, 1 slave flag, 2 bus idle
    task automatic wt(input int s);
        int k;
        k = 0;
        while (!(s == 0 ? master_on_bus_flag === 1'b1 :
            s == 1 ? slave_on_bus_flag === 1'b1 : bus_busy === 1'b0)
            && k < 5000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 5000) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic wa(input logic [10:0] v, input logic h, input logic t);
        addr_val = v;
        high_speed_select = h;
        ten_bit_addr_enable = t;
        addr_wr = 1'b1;
        @(negedge clk);
        addr_wr = 1'b0;
    endtask
    // stop also drops both flags; a short gap lets busy settle
    task automatic stop();
        cmd_stop = 1'b1;
        mb_clr = 1'b1;
        sb_clr = 1'b1;
        @(negedge clk);
        cmd_stop = 1'b0;
        mb_clr = 1'b0;
        sb_clr = 1'b0;
        repeat (3) @(negedge clk);
        wt(2);
    endtask
    task automatic cont();
        cmd_continue = 1'b1;
        sb_clr = 1'b1;
        @(negedge clk);
        cmd_continue = 1'b0;
        sb_clr = 1'b0;
    endtask
    task automatic pop(input int k);
        rx_ready = 1'b1;
        repeat (k) @(negedge clk);
        rx_ready = 1'b0;
    endtask
    // the slave's bytes, oldest note first
    always @(got_cnt) begin
        check("byte", got_byte, wq.size() ? wq.pop_front() : 8'hxx);
        check("early flag", {7'h00, master_on_bus_flag}, 8'h00);
    end
    // each pop must hand over the oldest byte sent
    always @(posedge clk) if (rx_valid === 1'b1 && rx_ready === 1'b1)
        check("rx data", rx_data, rq.size() ? rq.pop_front() : 8'hxx);
    initial begin
        logic [9:0] a;
        logic [7:0] r;
        int n0;
        {addr_wr, high_speed_select, ten_bit_addr_enable, ack_action} = 4'h0;
        {clock_stretch_mode, cmd_continue, cmd_stop, mb_clr} = 4'h0;
        {sb_clr, rx_ready, clash, slow} = 4'h0;
        {ack_en, addr_val, bus_speed, rd_byte} = 22'h200000;
        void'($urandom(61715));
        repeat (8) @(negedge clk);
        check("reset", st, 8'h00);
        rst_n = 1'b1;
        // plain write held until cleared
        wq.push_back(8'hA4);
        wa(11'h0A4, 1'b0, 1'b0);
        wt(0);
        repeat (200) @(negedge clk);
        check("held", st & 8'hDE, 8'h86);
        stop();
        check("stopped", st, 8'h00);
        // ten-bit, first byte refused
        ack_en = 1'b0;
        a = 10'($urandom);
        wq.push_back({5'h1E, a[9:8], 1'b0});
        wa({a, 1'b0}, 1'b0, 1'b1);
        wt(0);
        check("ten nack", st & 8'hBC, 8'hA4);
        stop();
        // ten-bit write under a slow slave, then read by repeated start
        {ack_en, slow} = 2'h3;
        a = 10'($urandom);
        wq.push_back({5'h1E, a[9:8], 1'b0});
        wq.push_back(a[7:0]);
        wa({a, 1'b0}, 1'b0, 1'b1);
        wt(0);
        check("ten write", st & 8'hDC, 8'h84);
        slow = 1'b0;
        r = 8'($urandom);
        rd_byte = r;
        rq.push_back(r);
        wq.push_back({5'h1E, a[9:8], 1'b1});
        wa({a, 1'b1}, 1'b0, 1'b1);
        wt(1);
        check("ten read", st & 8'h54, 8'h44);
        ack_action = 1'b1;
        stop();
        pop(1);
        check("last ack", {7'h00, mack}, 8'h01);
        // fill the buffer until it refuses, then drain it
        ack_action = 1'b0;
        wq.push_back(8'hA5);
        for (int i = 0; i < 9; i++) begin
            r = 8'($urandom);
            rd_byte = r;
            rq.push_back(r);
            if (i == 0) wa(11'h0A5, 1'b0, 1'b0);
            else cont();
            if (i < 8) wt(1);
        end
        repeat (1000) @(negedge clk);
        check("full stall", st & 8'h42, 8'h02);
        pop(8);
        wt(1);
        ack_action = 1'b1;
        stop();
        pop(1);
        // smart mode: flag only once the ack bit has gone out
        {clock_stretch_mode, ack_action} = 2'h2;
        r = 8'($urandom);
        rd_byte = r;
        rq.push_back(r);
        rq.push_back(r);
        wq.push_back(8'hA7);
        n0 = acks;
        wa(11'h0A7, 1'b0, 1'b0);
        wt(1);
        check("smart acks", 8'(acks - n0), 8'h01);
        check("smart ack", {7'h00, mack}, 8'h00);
        ack_action = 1'b1;
        pop(1);
        wt(1);
        check("smart acks", 8'(acks - n0), 8'h02);
        check("smart nack", {7'h00, mack}, 8'h01);
        stop();
        pop(1);
        // lost arbitration at full speed
        {clock_stretch_mode, clash} = 2'h1;
        wa(11'h0A4, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        wt(2);
        check("arb lost", st & 8'hDC, 8'h90);
        clash = 1'b0;
        stop();
        // high-speed entry, repeated starts, stop
        bus_speed = SPEED_HS;
        clock_stretch_mode = 1'b1;
        wq.push_back(8'h0D);
        wa(11'h00D, 1'b0, 1'b0);
        wt(0);
        check("master code", st & 8'hDC, 8'h84);
        clash = 1'b1;
        wq.push_back(8'h00);
        wa(11'h052, 1'b1, 1'b0);
        repeat (400) @(negedge clk);
        check("hs addr", st & 8'hDC, 8'h8C);
        check("no arb", st & 8'h10, 8'h00);
        clash = 1'b0;
        wq.push_back(8'h54);
        wa(11'h054, 1'b1, 1'b0);
        repeat (400) @(negedge clk);
        check("hs again", st & 8'hDC, 8'h8C);
        stop();
        check("hs end", st & 8'h0C, 8'h00);
        check("bytes left", 8'(wq.size() + rq.size()), 8'h00);
        conclude();
    end
endmodule
